// ### src/hwst_ctrl.sv
/*
  external start-trigger exposure controller: arming, edge selection, timed
  and pulse-width exposure, overrun event and readout extension.
  assumes line inputs and readout_busy_i are synchronous to clk_i.
*/
`timescale 1ns/1ps
//
// Function
// - enabled with a line source, that line is the start trigger
// - polarity setting picks rising or falling start edges
// - when armed, a selected edge starts frame acquisition
// - leave armed on start; rearm automatically when ready again
// - edges arriving while not armed are discarded
// - one frame per accepted trigger
// - exactly two exposure policies: fixed and pulse width
// - fixed policy: start on selected edge, last programmed time
// - fixed policy: trigger during exposure ignored, overrun raised
// - pulse width rising: expose from rise to next fall
// - pulse width still uses programmed time for armed indicator
// - pulse end during readout extends exposure until readout ends
module hwst_ctrl
  import hwst_pkg::*;
#(
  parameter int EXPO_W = HWST_EXPO_W
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        clk_en_i,
  // trigger input lines
  input  wire logic        line1_i,
  input  wire logic        line2_i,
  // readout status from sensor side
  input  wire logic        readout_busy_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [31:0] rdata_o,
  // exposure and status outputs
  output logic             expose_o,
  output logic             frame_start_o,
  output logic             armed_o,
  output logic             overrun_o
);

  hwst_state_t       state_q;
  logic [HWST_CTRL_W-1:0] ctrl_q;
  logic [EXPO_W-1:0] expo_q;
  logic [EXPO_W-1:0] cnt_q;
  logic              min_done_q;
  logic              ovr_q;
  logic [15:0]       frames_q;
  logic              start_edge;
  logic              end_edge;
  logic              line_sel;
  logic              width_mode;
  logic              ovl_mode;

  // width bit picks one of two policies
  assign width_mode = ctrl_q[HWST_CTRL_WIDTH_BIT];
  assign ovl_mode   = ctrl_q[HWST_CTRL_OVL_BIT];

  assign line_sel = ctrl_q[HWST_CTRL_SRC_BIT] ? line2_i : line1_i;

  hwst_edge u_edge (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .clk_en_i (clk_en_i),
    .line_i   (line_sel),
    .fall_i   (ctrl_q[HWST_CTRL_FALL_BIT]),
    .start_o  (start_edge),
    .end_o    (end_edge)
  );

  // control and exposure registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= HWST_CTRL_RST;
      expo_q <= EXPO_W'(HWST_EXPO_RST);
    end else if (clk_en_i && we_i) begin
      if (addr_i == HWST_CTRL_OFS) begin
        ctrl_q <= wdata_i[HWST_CTRL_W-1:0];
      end
      if (addr_i == HWST_EXPO_OFS) begin
        expo_q <= wdata_i[EXPO_W-1:0];
      end
    end
  end

  // exposure state machine
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= HWST_OFF;
    end else if (clk_en_i) begin
      unique case (state_q)
        HWST_OFF: begin
          if (ctrl_q[HWST_CTRL_EN_BIT]) begin
            state_q <= HWST_ARMED;
          end
        end
        HWST_ARMED: begin
          if (!ctrl_q[HWST_CTRL_EN_BIT]) begin
            state_q <= HWST_OFF;
          end else if (start_edge) begin
            state_q <= HWST_EXPOSE;
          end
        end
        HWST_EXPOSE: begin
          if (!width_mode && cnt_q <= EXPO_W'(1)) begin
            state_q <= HWST_ARMED;
          end else if (width_mode && end_edge) begin
            if (ovl_mode && readout_busy_i) begin
              state_q <= HWST_EXTEND;
            end else begin
              state_q <= HWST_ARMED;
            end
          end
        end
        HWST_EXTEND: begin
          if (!readout_busy_i) begin
            state_q <= HWST_ARMED;
          end
        end
        default: state_q <= HWST_OFF;
      endcase
    end
  end

  // exposure timer, loaded on start
  // a zero count still exposes for one cycle, never for none
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q      <= '0;
      min_done_q <= 1'b0;
    end else if (clk_en_i) begin
      if (state_q == HWST_ARMED && start_edge) begin
        cnt_q      <= expo_q;
        min_done_q <= 1'b0;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - EXPO_W'(1);
      end else begin
        min_done_q <= 1'b1;
      end
    end
  end

  // outputs: exposure, frame pulse, armed, overrun
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      expose_o      <= 1'b0;
      frame_start_o <= 1'b0;
      armed_o       <= 1'b0;
      overrun_o     <= 1'b0;
    end else if (clk_en_i) begin
      expose_o      <= (state_q == HWST_EXPOSE) || (state_q == HWST_EXTEND);
      frame_start_o <= (state_q == HWST_ARMED) && start_edge &&
                       ctrl_q[HWST_CTRL_EN_BIT];
      // ready only after programmed minimum time
      armed_o       <= (state_q == HWST_ARMED) ||
                       (width_mode && state_q == HWST_EXPOSE && min_done_q);
      overrun_o     <= !width_mode && (state_q == HWST_EXPOSE) && start_edge;
    end
  end

  // sticky overrun flag, set wins so a clear in the same cycle cannot
  // hide a new overrun; frame counter of accepted starts
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovr_q    <= 1'b0;
      frames_q <= '0;
    end else if (clk_en_i) begin
      if (!width_mode && state_q == HWST_EXPOSE && start_edge) begin
        ovr_q <= 1'b1;
      end else if (we_i && addr_i == HWST_STAT_OFS &&
                   wdata_i[HWST_STAT_OVR_BIT]) begin
        ovr_q <= 1'b0;
      end
      if (state_q == HWST_ARMED && start_edge && ctrl_q[HWST_CTRL_EN_BIT]) begin
        frames_q <= frames_q + 16'h0001;
      end
    end
  end

  // read data one cycle after strobe
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      rdata_o <= 32'h0000_0000;
      if (re_i) begin
        unique case (addr_i)
          HWST_CTRL_OFS:  rdata_o <= {{(32-HWST_CTRL_W){1'b0}}, ctrl_q};
          HWST_EXPO_OFS:  rdata_o <= {{(32-EXPO_W){1'b0}}, expo_q};
          HWST_STAT_OFS:  rdata_o <= {29'h0, ovr_q,
                                      state_q[2] | state_q[3], state_q[1]};
          HWST_COUNT_OFS: rdata_o <= {16'h0000, frames_q};
          default:        rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // assertion steps: start taken, timed end, retrigger, pulse ends
  sequence s_start_taken;
    clk_en_i && state_q == HWST_ARMED && start_edge &&
    ctrl_q[HWST_CTRL_EN_BIT];
  endsequence

  sequence s_fixed_last;
    clk_en_i && !width_mode && state_q == HWST_EXPOSE &&
    cnt_q == EXPO_W'(1);
  endsequence

  sequence s_fixed_retrigger;
    clk_en_i && !width_mode && state_q == HWST_EXPOSE && start_edge;
  endsequence

  sequence s_pulse_end_free;
    clk_en_i && width_mode && state_q == HWST_EXPOSE && end_edge &&
    !(ovl_mode && readout_busy_i);
  endsequence

  sequence s_pulse_end_busy;
    clk_en_i && width_mode && ovl_mode && state_q == HWST_EXPOSE &&
    end_edge && readout_busy_i;
  endsequence

  sequence s_readout_done;
    clk_en_i && state_q == HWST_EXTEND && !readout_busy_i;
  endsequence

  // armed state left on an accepted start
  AST_LEAVE_ARMED: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    s_start_taken |=> state_q == HWST_EXPOSE)
    else $error("armed state not left on start edge");

  // accepted start gives a frame pulse
  AST_FRAME_PULSE: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    s_start_taken |=> frame_start_o)
    else $error("accepted start gave no frame pulse");

  AST_FIXED_LEN: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    s_fixed_last |=> state_q == HWST_ARMED)
    else $error("fixed exposure did not end on time");

  AST_OVERRUN: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    s_fixed_retrigger |=> overrun_o && ovr_q && !frame_start_o)
    else $error("overrun not raised");

  AST_DISCARD: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    clk_en_i && state_q != HWST_ARMED |=> !frame_start_o)
    else $error("frame started while not armed");

  AST_PULSE_END: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    s_pulse_end_free |=> state_q == HWST_ARMED)
    else $error("pulse end did not stop exposure");

  // pulse end during readout keeps exposing
  AST_EXTEND_START: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    s_pulse_end_busy |=> state_q == HWST_EXTEND ##1 expose_o)
    else $error("exposure not extended over readout");

  AST_EXTEND: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    state_q == HWST_EXTEND && readout_busy_i |=> state_q == HWST_EXTEND)
    else $error("extension ended during readout");

  AST_REARM: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    s_readout_done |=> state_q == HWST_ARMED)
    else $error("not rearmed after readout");

  AST_WIDTH_WAIT: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    clk_en_i && width_mode && state_q == HWST_EXPOSE && !min_done_q
    |=> !armed_o)
    else $error("armed indicator early in width mode");

  // overrun belongs to the timed policy only
  AST_NO_WIDTH_OVR: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    clk_en_i && width_mode |=> !overrun_o)
    else $error("overrun raised in width mode");

endmodule // hwst_ctrl

// ### inc/hwst_pkg.sv
/*
  package for the external start-trigger exposure controller: register map,
  field positions, reset values and state codes.
  assumes a single 100 MHz clock domain.
*/
package hwst_pkg;

  // register offsets (byte addresses, one word each)
  localparam logic [7:0] HWST_CTRL_OFS   = 8'h00;
  localparam logic [7:0] HWST_EXPO_OFS   = 8'h04;
  localparam logic [7:0] HWST_STAT_OFS   = 8'h08;
  localparam logic [7:0] HWST_COUNT_OFS  = 8'h0c;

  // control register fields
  localparam int HWST_CTRL_EN_BIT     = 0;
  localparam int HWST_CTRL_SRC_BIT    = 1;
  localparam int HWST_CTRL_FALL_BIT   = 2;
  localparam int HWST_CTRL_WIDTH_BIT  = 3;
  localparam int HWST_CTRL_OVL_BIT    = 4;
  localparam int HWST_CTRL_W          = 5;
  localparam logic [4:0] HWST_CTRL_RST = 5'h00;

  // status register fields
  localparam int HWST_STAT_ARMED_BIT  = 0;
  localparam int HWST_STAT_EXPO_BIT   = 1;
  localparam int HWST_STAT_OVR_BIT    = 2;

  // exposure duration in clock cycles
  localparam int          HWST_EXPO_W   = 24;
  localparam logic [23:0] HWST_EXPO_RST = 24'h000064;

  // clock
  localparam int HWST_CLK_NS = 10;

  // controller states
  typedef enum logic [3:0] {
    HWST_OFF     = 4'b0001,
    HWST_ARMED   = 4'b0010,
    HWST_EXPOSE  = 4'b0100,
    HWST_EXTEND  = 4'b1000
  } hwst_state_t;

endpackage

// ### src/hwst_edge.sv
/*
  edge detector for one synchronous input line with selectable polarity.
  assumes the line is already synchronous to clk_i.
*/
`timescale 1ns/1ps
module hwst_edge (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic clk_en_i,
  // line and polarity
  input  wire logic line_i,
  input  wire logic fall_i,
  // detected edges
  output logic      start_o,
  output logic      end_o
);

  logic line_q;
  logic vld_q;

  // previous sample of the line; vld_q blocks edges until one real
  // sample is held, so a line idling high gives no false edge on reset
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_q <= 1'b0;
      vld_q  <= 1'b0;
    end else if (clk_en_i) begin
      line_q <= line_i;
      vld_q  <= 1'b1;
    end
  end

  // start edge follows polarity, end edge is the opposite one
  always_comb begin
    start_o = vld_q & (fall_i ? (line_q & ~line_i) : (~line_q & line_i));
    end_o   = vld_q & (fall_i ? (~line_q & line_i) : (line_q & ~line_i));
  end

endmodule // hwst_edge

// ### test/hwst_src_model.sv
/*
  external trigger source driving the two line inputs.
  assumes its tasks are called from a bench clocked by clk_i.
*/
`timescale 1ns/1ps
module hwst_src_model (
  // clock
  input  wire logic clk_i,
  // trigger lines
  output logic      line1_o,
  output logic      line2_o
);
  // lines start low
  initial begin
    line1_o = 1'b0;
    line2_o = 1'b0;
  end

  // set idle level of both lines
  task automatic idle(input logic lvl);
    @(posedge clk_i);
    line1_o <= lvl;
    line2_o <= lvl;
  endtask

  // invert the chosen line
  task automatic flip(input logic sel);
    if (sel) begin
      line2_o <= ~line2_o;
    end else begin
      line1_o <= ~line1_o;
    end
  endtask

  task automatic pulse(input logic sel, input int hi, input int gap);
    @(posedge clk_i);
    flip(sel);
    repeat (hi) @(posedge clk_i);
    flip(sel);
    repeat (gap) @(posedge clk_i);
  endtask
endmodule // hwst_src_model

// ### test/hwst_ctrl_tb_top.sv
/*
  bench for the start-trigger exposure controller: reset, then trigger table,
  overrun, armed indicator, readout extension, clock enable freeze and mid-run reset cases.
  assumes the trigger source model hwst_src_model.
*/
`timescale 1ns/1ps
module hwst_ctrl_tb_top;
  import hwst_pkg::*;
  typedef struct {
    logic [4:0]  ctrl;
    logic        sel;
    int          hi;
    int          nf;
    int          ne;
    logic [31:0] stat;
  } hwst_row_t;
  logic        clk_i, arst_n_i, busy, we, re, l1, l2, ce;
  logic        expose, fs, armed, ovr;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  int          n_errors, n_checks, nf, ne, no, total;
  // ctrl, line, pulse cycles, frames, exposure cycles, status
  hwst_row_t   rows [8] = '{
    '{5'h01, 1'b0, 3, 1, 5, 32'h1},
    '{5'h05, 1'b0, 3, 1, 5, 32'h1},
    '{5'h03, 1'b1, 3, 1, 5, 32'h1},
    '{5'h07, 1'b1, 3, 1, 5, 32'h1},
    '{5'h01, 1'b1, 3, 0, 0, 32'h1},
    '{5'h09, 1'b0, 8, 1, 8, 32'h1},
    '{5'h0f, 1'b1, 8, 1, 8, 32'h1},
    '{5'h00, 1'b0, 3, 0, 0, 32'h0}};

  hwst_ctrl hwst_ctrl_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .clk_en_i(ce), .line1_i(l1), .line2_i(l2), .readout_busy_i(busy),
    .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
    .rdata_o(rdata), .expose_o(expose), .frame_start_o(fs),
    .armed_o(armed), .overrun_o(ovr));
  hwst_src_model hwst_src_model_inst (.clk_i(clk_i), .line1_o(l1),
    .line2_o(l2));

  // clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // count frames, exposure cycles and overruns
  always @(posedge clk_i) begin
    if (fs === 1'b1) nf++;
    if (expose === 1'b1) ne++;
    if (ovr === 1'b1) no++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk_i);
    we    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input string what);
    @(posedge clk_i);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk_i);
    re   <= 1'b0;
    #1;
    chk(rdata, exp, what);
  endtask

  task automatic clr();
    @(negedge clk_i);
    nf = 0;
    ne = 0;
    no = 0;
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    #200000;
    n_errors++;
    conclude();
  end

  // main sequence
  initial begin
    {arst_n_i, busy, we, re, addr, wdata} = '0;
    ce = 1'b1;
    {n_errors, n_checks, total} = '0;
    repeat (15) @(posedge clk_i);
    #1;
    chk({28'h0, expose, fs, armed, ovr}, 32'h0, "reset outputs");
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(HWST_CTRL_OFS, 32'h0, "ctrl reset");
    rd(HWST_EXPO_OFS, 32'h64, "expo reset");
    rd(8'h10, 32'h0, "unmapped");
    wr(HWST_EXPO_OFS, 32'h5);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(HWST_CTRL_OFS, 32'h0);
      hwst_src_model_inst.idle(rows[i].ctrl[HWST_CTRL_FALL_BIT]);
      wr(HWST_CTRL_OFS, {27'h0, rows[i].ctrl});
      clr();
      hwst_src_model_inst.pulse(rows[i].sel, rows[i].hi, 20);
      chk(nf, rows[i].nf, "frames");
      chk(ne, rows[i].ne, "exposure");
      rd(HWST_STAT_OFS, rows[i].stat, "rearm");
      total += rows[i].nf;
      $display("test row %0d done", i);
    end
    // second edge inside a timed exposure
    wr(HWST_CTRL_OFS, 32'h0);
    hwst_src_model_inst.idle(1'b0);
    wr(HWST_EXPO_OFS, 32'h14);
    wr(HWST_CTRL_OFS, 32'h1);
    clr();
    hwst_src_model_inst.pulse(1'b0, 2, 4);
    hwst_src_model_inst.pulse(1'b0, 2, 40);
    chk(nf, 1, "overrun frames");
    chk(no, 1, "overrun event");
    chk(ne, 20, "overrun exposure");
    rd(HWST_STAT_OFS, 32'h5, "overrun sticky");
    wr(HWST_STAT_OFS, 32'h4);
    rd(HWST_STAT_OFS, 32'h1, "overrun clear");
    $display("test overrun done");
    // armed indicator in width mode
    wr(HWST_EXPO_OFS, 32'h5);
    wr(HWST_CTRL_OFS, 32'h9);
    fork
      hwst_src_model_inst.pulse(1'b0, 12, 20);
      begin
        repeat (3) @(posedge clk_i);
        #1;
        chk({30'h0, expose, armed}, 32'h2, "width waiting");
        repeat (7) @(posedge clk_i);
        #1;
        chk({30'h0, expose, armed}, 32'h3, "width armed");
      end
    join
    $display("test armed done");
    // pulse ends during readout
    wr(HWST_CTRL_OFS, 32'h19);
    busy <= 1'b1;
    fork
      hwst_src_model_inst.pulse(1'b0, 4, 30);
      begin
        repeat (10) @(posedge clk_i);
        #1;
        chk({31'h0, expose}, 32'h1, "extended");
        @(posedge clk_i);
        busy <= 1'b0;
        repeat (5) @(posedge clk_i);
        #1;
        chk({31'h0, expose}, 32'h0, "extension end");
      end
    join
    $display("test extension done");
    // clock enable low freezes a timed exposure in place
    wr(HWST_CTRL_OFS, 32'h1);
    clr();
    fork
      hwst_src_model_inst.pulse(1'b0, 2, 20);
      begin
        repeat (3) @(posedge clk_i);
        ce <= 1'b0;
        repeat (4) @(posedge clk_i);
        ce <= 1'b1;
      end
    join
    chk(nf, 1, "frozen frames");
    chk(ne, 9, "frozen exposure");
    rd(HWST_COUNT_OFS, total + 4, "frame count");
    $display("test freeze done");
    // reset in mid-run brings outputs and registers back to defaults
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk({rdata[27:0], expose, fs, armed, ovr}, 32'h0, "mid reset outputs");
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(HWST_CTRL_OFS, 32'h0, "mid reset ctrl");
    rd(HWST_EXPO_OFS, 32'h64, "mid reset expo");
    rd(HWST_COUNT_OFS, 32'h0, "mid reset count");
    $display("test mid reset done");
    conclude();
  end
endmodule // hwst_ctrl_tb_top
